// [testbench/jtl_regs_sva.sv]
// Purpose: Port assertions for the link parameter register bank
// Assumes: Byte address is four times the register index
// Notes:   Bound to every instance of the bank
`timescale 1ns/100ps
`include "jtl_link_params_params.svh"

module jtl_regs_sva
  import jtl_pkg::*;
#(
  parameter int         ADDR_W     = 16,
  parameter logic [4:0] LANES_CODE = `JTL_RST_LANES,
  parameter logic [7:0] OCTETS_VAL = `JTL_RST_OCTETS,
  parameter logic [7:0] CONV_CODE  = `JTL_RST_CONV
) (
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic [31:0]       S_AXI_WDATA,
  input wire logic [3:0]        S_AXI_WSTRB,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic [7:0]        DEVICE_IDENT,
  input wire logic [3:0]        BANK_IDENT,
  input wire logic [4:0]        LANE_IDENT_0,
  input wire logic [4:0]        LANE_IDENT_1,
  input wire logic              DATA_WHITENING_ON,
  input wire logic [4:0]        LANE_COUNT_CODE,
  input wire logic [7:0]        OCTETS_CODE,
  input wire logic [4:0]        MULTIFRAME_CODE,
  input wire logic [7:0]        CONVERTER_CODE,
  input wire logic [1:0]        CONTROL_BITS_SEL,
  input wire logic [7:0]        LANE_CHECKSUM_0,
  input wire logic [7:0]        LANE_CHECKSUM_1,
  input wire logic [3:0]        ILAS_CFG_INDEX,
  input wire logic [7:0]        ILAS_CFG_OCTET_0
);

  // ****************************************
  // Helpers
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic [7:0] base;
  logic [7:0] sum0;
  logic [7:0] sum1;

  // Shared part of both lane sums; wraps at 256 by width
  assign base = DEVICE_IDENT + BANK_IDENT + DATA_WHITENING_ON
              + LANE_COUNT_CODE + OCTETS_CODE + MULTIFRAME_CODE
              + CONVERTER_CODE + CONTROL_BITS_SEL;
  assign sum0 = base + LANE_IDENT_0;
  assign sum1 = base + LANE_IDENT_1;

  // Write taken whole in one edge, low byte enabled
  sequence s_wr(logic [11:0] i);
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY &&
    S_AXI_WSTRB[0] && S_AXI_AWADDR == {2'b00, i, 2'b00};
  endsequence

  sequence s_rd(logic [11:0] i);
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == {2'b00, i, 2'b00};
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_fixed_codes: assert property (
    LANE_COUNT_CODE == LANES_CODE && OCTETS_CODE == OCTETS_VAL &&
    CONVERTER_CODE == CONV_CODE) else $error("read-only code moved");
  // Field lands on the edge after both halves are held, one after taking; sampled two after
  a_whiten_write: assert property (s_wr(`JTL_IDX_WHITEN) |=> ##1
    DATA_WHITENING_ON == $past(S_AXI_WDATA[7], 2))
    else $error("whitening bit not written");
  a_kcode_write: assert property (s_wr(`JTL_IDX_MFRAME) |=> ##1
    MULTIFRAME_CODE == $past(S_AXI_WDATA[4:0], 2))
    else $error("multiframe code not written");
  a_ctrl_write: assert property (s_wr(`JTL_IDX_CTRLB) |=> ##1
    CONTROL_BITS_SEL == $past(S_AXI_WDATA[7:6], 2))
    else $error("control bit select not written");
  a_dev_read: assert property (s_rd(`JTL_IDX_DEV) |=>
    S_AXI_RVALID && S_AXI_RDATA == {24'h0, $past(DEVICE_IDENT)})
    else $error("device ident read wrong");
  a_lanes_read: assert property (s_rd(`JTL_IDX_WHITEN) |=>
    S_AXI_RDATA == {24'h0, $past(DATA_WHITENING_ON), 2'b00, LANE_COUNT_CODE})
    else $error("whitening register read wrong");
  a_chk_lane0: assert property (!$past(SYS_RST) |->
    LANE_CHECKSUM_0 == $past(sum0)) else $error("lane 0 sum wrong");
  a_chk_lane1: assert property (!$past(SYS_RST) |->
    LANE_CHECKSUM_1 == $past(sum1)) else $error("lane 1 sum wrong");
  a_ilas_dev: assert property (!$past(SYS_RST) &&
    $past(ILAS_CFG_INDEX) == 4'h0 |-> ILAS_CFG_OCTET_0 == $past(DEVICE_IDENT))
    else $error("alignment octet 0 wrong");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");

endmodule

bind jtl_link_param_regs jtl_regs_sva #(
  .ADDR_W(ADDR_W), .LANES_CODE(LANES_CODE), .OCTETS_VAL(OCTETS_VAL),
  .CONV_CODE(CONV_CODE)
) u_sva (.*);

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the link parameter register bank
// Assumes: 20 MHz clock, AXI4-Lite master driven on rising edges
// Notes:   Read ready is raised late to exercise the hold of read data
`timescale 1ns/100ps

module testbench;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb, idx;
  wire         awready, wready, bvalid, arready, rvalid, whiten;
  wire  [1:0]  bresp, rresp, cs;
  wire  [31:0] rdata;
  wire  [7:0]  device_ident, chk0, chk1, oct0, oct1, fcode, mcode;
  wire  [4:0]  lid0, lid1, kcode, lcode;
  wire  [3:0]  bank_ident;
  int          err_count, checked;

  // Register table: address, reset, write value, read back
  logic [15:0] adr  [9] = '{16'h1600, 16'h1604, 16'h160c, 16'h1614,
                            16'h162c, 16'h1630, 16'h1634, 16'h1638, 16'h163c};
  logic [7:0]  rstv [9] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h81, 8'h01,
                            8'h1f, 8'h01, 8'h00};
  logic [7:0]  wv   [9] = '{8'hff, 8'hff, 8'hff, 8'h05, 8'h7f, 8'h00,
                            8'he3, 8'h00, 8'hbf};
  logic [7:0]  rbv  [9] = '{8'hff, 8'h0f, 8'h1f, 8'h05, 8'h01, 8'h01,
                            8'h03, 8'h01, 8'h80};

  jtl_link_param_regs uut (
    .CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DEVICE_IDENT(device_ident),
    .BANK_IDENT(bank_ident), .LANE_IDENT_0(lid0), .LANE_IDENT_1(lid1),
    .DATA_WHITENING_ON(whiten), .LANE_COUNT_CODE(lcode),
    .OCTETS_CODE(fcode), .MULTIFRAME_CODE(kcode),
    .CONVERTER_CODE(mcode), .CONTROL_BITS_SEL(cs),
    .LANE_CHECKSUM_0(chk0), .LANE_CHECKSUM_1(chk1),
    .ILAS_CFG_INDEX(idx), .ILAS_CFG_OCTET_0(oct0), .ILAS_CFG_OCTET_1(oct1));

  // ****************************************
  // Clock, compare, bus tasks
  // ****************************************
  always #25 clk = ~clk;

  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Response ready held from the start; waits are bounded
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    cmp($sformatf("bvalid %h", a), 32'h1, {31'h0, bvalid});
    cmp($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
  endtask

  // Ready raised only once data shows, so data must stand a cycle
  task automatic rd(input logic [15:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    cmp($sformatf("rvalid %h", a), 32'h1, {31'h0, rvalid});
    cmp($sformatf("rdata %h", a), e, rdata);
    cmp($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
  endtask

  // Alignment octet layout per index
  function automatic logic [7:0] oct_exp(int i, logic [7:0] lane_ident, ck);
    case (i)
      0: return 8'hff;
      1: return 8'h0f;
      2: return lane_ident;
      3: return 8'h81;
      4, 6: return 8'h01;
      5: return 8'h03;
      7: return 8'hc0;
      13: return ck;
      default: return 8'h00;
    endcase
  endfunction

  task automatic conclude();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    clk = 0; rst = 1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    idx = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(adr[i], rstv[i], 2'b00);
    cmp("chk0", 8'h23, chk0);
    cmp("chk1", 8'h25, chk1);
    cmp("lcode", 5'h01, lcode);
    cmp("fcode", 8'h01, fcode);
    cmp("mcode", 8'h01, mcode);
    // Reserved and read-only bits must ignore the set bits of the table writes
    for (int i = 0; i < 9; i++) begin
      wr(adr[i], {24'h0, wv[i]}, 4'h1, 2'b00);
      rd(adr[i], {24'h0, rbv[i]}, 2'b00);
    end
    cmp("kcode", 5'h03, kcode);
    cmp("bid", 4'hf, bank_ident);
    cmp("lid0", 5'h1f, lid0);
    cmp("whiten", 1'b0, whiten);
    wr(16'h1600, 32'h0, 4'h0, 2'b00);
    cmp("did", 8'hff, device_ident);
    wr(16'h1608, 32'hff, 4'h1, 2'b10);
    rd(16'h1608, 32'h0, 2'b10);
    for (int c = 0; c < 4; c++) begin
      wr(16'h163c, {24'h0, c[1:0], 6'h0}, 4'h1, 2'b00);
      cmp("cs", c, cs);
    end
    wr(16'h162c, 32'h80, 4'h1, 2'b00);
    cmp("whiten", 1'b1, whiten);
    // Sum 0xff+0xf+1+1+1+3+1+3 plus lane ident, mod 256
    // Sums lag the fields by one edge; look once that edge has settled
    #1;
    cmp("chk0", 8'h37, chk0);
    cmp("chk1", 8'h1d, chk1);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      idx <= i[3:0];
      @(posedge clk);
      #1;
      cmp($sformatf("oct0 %0d", i), oct_exp(i, 8'h1f, 8'h37), oct0);
      cmp($sformatf("oct1 %0d", i), oct_exp(i, 8'h05, 8'h1d), oct1);
    end
    // Second reset in mid-run brings back the reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp("did", 8'h00, device_ident);
    cmp("lid1", 5'h02, lid1);
    cmp("chk0", 8'h23, chk0);
    conclude();
  end

  // Tests take well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    conclude();
  end

endmodule

// [verilog/jtl_link_param_regs.sv]
// Purpose: AXI4-Lite register bank for the serial link parameters
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read-only fields come from parameters; unmapped answers SLVERR
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "jtl_link_params_params.svh"

module jtl_link_param_regs
  import jtl_pkg::*;
#(
  parameter int              ADDR_W     = 16,
  parameter logic [4:0]      LANES_CODE = `JTL_RST_LANES,
  parameter logic [7:0]      OCTETS_VAL = `JTL_RST_OCTETS,
  parameter logic [7:0]      CONV_CODE  = `JTL_RST_CONV
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Link parameters to the transmitter
  output logic [7:0]             DEVICE_IDENT,
  output logic [3:0]             BANK_IDENT,
  output logic [4:0]             LANE_IDENT_0,
  output logic [4:0]             LANE_IDENT_1,
  output logic                   DATA_WHITENING_ON,
  output logic [4:0]             LANE_COUNT_CODE,
  output logic [7:0]             OCTETS_CODE,
  output logic [4:0]             MULTIFRAME_CODE,
  output logic [7:0]             CONVERTER_CODE,
  output logic [1:0]             CONTROL_BITS_SEL,
  output logic [7:0]             LANE_CHECKSUM_0,
  output logic [7:0]             LANE_CHECKSUM_1,
  // Alignment sequence configuration octets
  input  wire logic [3:0]        ILAS_CFG_INDEX,
  output logic [7:0]             ILAS_CFG_OCTET_0,
  output logic [7:0]             ILAS_CFG_OCTET_1
);

  // ****************************************
  // Stored fields
  // ****************************************
  logic [7:0] dev_ident_r;
  logic [3:0] bank_ident_r;
  logic [4:0] lane_ident0_r;
  logic [4:0] lane_ident1_r;
  logic       whitening_r;
  logic [4:0] mframe_r;
  jtl_cs_t    ctrlb_r;

  // ****************************************
  // Bus state, checksums and octets
  // ****************************************
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [ADDR_W-1:0]     awaddr_r;
  logic [7:0]            wbyte_r;
  logic                  wlane_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [1:0]            rresp_r;
  logic [31:0]           rdata_r;
  logic                  wr_go;
  logic [`JTL_IDX_W-1:0] widx;
  logic                  wmapped;
  logic [`JTL_IDX_W-1:0] ridx;
  logic [7:0]            rd_byte;
  logic                  rd_hit;
  logic [7:0]            chk0_nxt;
  logic [7:0]            chk1_nxt;
  logic [7:0]            chk0_r;
  logic [7:0]            chk1_r;
  logic [7:0]            oct0_r;
  logic [7:0]            oct1_r;

  // ****************************************
  // Helpers
  // ****************************************
  // Byte address to register index; upper bits must be clear
  function automatic logic [`JTL_IDX_W-1:0] to_idx(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] sh;
    sh = a >> 2;
    return sh[`JTL_IDX_W-1:0];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] sh;
    sh = a >> (`JTL_IDX_W + 2);
    return (sh == '0);
  endfunction

  // Sum of one lane's fields, wrapping at eight bits
  function automatic logic [7:0] lane_sum(input logic [4:0] lane_ident);
    logic [7:0] s;
    s = dev_ident_r + {4'h0, bank_ident_r} + {3'h0, lane_ident};
    s = s + {7'h00, whitening_r} + {3'h0, LANES_CODE};
    s = s + OCTETS_VAL + {3'h0, mframe_r} + CONV_CODE;
    s = s + {6'h00, ctrlb_r};
    return s;
  endfunction

  // Configuration octet at one position of the alignment sequence
  function automatic logic [7:0] cfg_octet(
    input logic [3:0] idx,
    input logic [4:0] lane_ident,
    input logic [7:0] chk
  );
    logic [7:0] o;
    o = 8'h00;
    unique case (idx)
      4'h0: o = dev_ident_r;
      4'h1: o = {4'h0, bank_ident_r};
      4'h2: o = {3'h0, lane_ident};
      4'h3: o = {whitening_r, 2'h0, LANES_CODE};
      4'h4: o = OCTETS_VAL;
      4'h5: o = {3'h0, mframe_r};
      4'h6: o = CONV_CODE;
      4'h7: o = {ctrlb_r, 6'h00};
      `JTL_ILAS_CHK_IDX: o = chk;
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  // Address and data may arrive in either order; each is held until used
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
  assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
  assign widx          = to_idx(awaddr_r);

  // Address capture
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  // Data capture; only the low lane carries register bits
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      w_held_r <= 1'b0;
      wbyte_r  <= 8'h00;
      wlane_r  <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      wbyte_r  <= S_AXI_WDATA[7:0];
      wlane_r  <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Which indices answer OKAY
  always_comb begin
    wmapped = 1'b0;
    if (addr_ok(awaddr_r)) begin
      unique case (widx)
        `JTL_IDX_DEV, `JTL_IDX_BANK, `JTL_IDX_LANE0, `JTL_IDX_LANE1,
        `JTL_IDX_WHITEN, `JTL_IDX_OCTETS, `JTL_IDX_MFRAME,
        `JTL_IDX_CONV, `JTL_IDX_CTRLB: wmapped = 1'b1;
        default: wmapped = 1'b0;
      endcase
    end
  end

  // Response; writes to read-only fields are dropped but answer OKAY
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `JTL_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wmapped ? `JTL_RESP_OKAY : `JTL_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Register updates
  // ****************************************
  // Identities; reserved upper bits are never stored
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dev_ident_r   <= `JTL_RST_DEV;
      bank_ident_r  <= `JTL_RST_BANK;
      lane_ident0_r <= `JTL_RST_LANE0;
      lane_ident1_r <= `JTL_RST_LANE1;
    end else if (wr_go && wlane_r && addr_ok(awaddr_r)) begin
      if (widx == `JTL_IDX_DEV) begin
        dev_ident_r <= wbyte_r; // RQ1
      end
      if (widx == `JTL_IDX_BANK) begin
        bank_ident_r <= wbyte_r[3:0]; // RQ2
      end
      if (widx == `JTL_IDX_LANE0) begin
        lane_ident0_r <= wbyte_r[4:0]; // RQ3
      end
      if (widx == `JTL_IDX_LANE1) begin
        lane_ident1_r <= wbyte_r[4:0]; // RQ4
      end
    end
  end

  // Link format settings; frame count legality is left to software
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      whitening_r <= `JTL_RST_WHITEN;
      mframe_r    <= `JTL_RST_MFRAME;
      ctrlb_r     <= JTL_CS_NONE;
    end else if (wr_go && wlane_r && addr_ok(awaddr_r)) begin
      if (widx == `JTL_IDX_WHITEN) begin
        whitening_r <= wbyte_r[`JTL_WHITEN_BIT]; // RQ5
      end
      if (widx == `JTL_IDX_MFRAME) begin
        mframe_r <= wbyte_r[4:0]; // RQ8 RQ9
      end
      if (widx == `JTL_IDX_CTRLB) begin
        ctrlb_r <= jtl_cs_t'(wbyte_r[`JTL_CTRLB_MSB:`JTL_CTRLB_LSB]); // RQ11
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign ridx          = to_idx(S_AXI_ARADDR);
  assign S_AXI_ARREADY = !rvalid_r;

  // Read mux; reserved and resolution bits read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = addr_ok(S_AXI_ARADDR);
    unique case (ridx)
      `JTL_IDX_DEV:    rd_byte = dev_ident_r;
      `JTL_IDX_BANK:   rd_byte = {4'h0, bank_ident_r};
      `JTL_IDX_LANE0:  rd_byte = {3'h0, lane_ident0_r};
      `JTL_IDX_LANE1:  rd_byte = {3'h0, lane_ident1_r};
      `JTL_IDX_WHITEN: rd_byte = {whitening_r, 2'h0, LANES_CODE}; // RQ6
      `JTL_IDX_OCTETS: rd_byte = OCTETS_VAL; // RQ7
      `JTL_IDX_MFRAME: rd_byte = {3'h0, mframe_r};
      `JTL_IDX_CONV:   rd_byte = CONV_CODE; // RQ10
      `JTL_IDX_CTRLB:  rd_byte = {ctrlb_r, 6'h00};
      default:         rd_hit  = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `JTL_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? `JTL_RESP_OKAY : `JTL_RESP_SLVERR;
      rdata_r  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Checksums and alignment octets
  // ****************************************
  assign chk0_nxt = lane_sum(lane_ident0_r);
  assign chk1_nxt = lane_sum(lane_ident1_r);

  // Registered so the adder tree stays off the output path
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      chk0_r <= 8'h00;
      chk1_r <= 8'h00;
    end else begin
      chk0_r <= chk0_nxt; // RQ12
      chk1_r <= chk1_nxt; // RQ12
    end
  end

  // Octet for the index asked one cycle earlier
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      oct0_r <= 8'h00;
      oct1_r <= 8'h00;
    end else begin
      oct0_r <= cfg_octet(ILAS_CFG_INDEX, lane_ident0_r, chk0_nxt); // RQ13
      oct1_r <= cfg_octet(ILAS_CFG_INDEX, lane_ident1_r, chk1_nxt); // RQ13
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign S_AXI_BVALID      = bvalid_r;
  assign S_AXI_BRESP       = bresp_r;
  assign S_AXI_RVALID      = rvalid_r;
  assign S_AXI_RRESP       = rresp_r;
  assign S_AXI_RDATA       = rdata_r;
  assign DEVICE_IDENT      = dev_ident_r; // RQ1
  assign BANK_IDENT        = bank_ident_r;
  assign LANE_IDENT_0      = lane_ident0_r;
  assign LANE_IDENT_1      = lane_ident1_r;
  assign DATA_WHITENING_ON = whitening_r; // RQ5
  assign LANE_COUNT_CODE   = LANES_CODE;
  assign OCTETS_CODE       = OCTETS_VAL;
  assign MULTIFRAME_CODE   = mframe_r;
  assign CONVERTER_CODE    = CONV_CODE;
  assign CONTROL_BITS_SEL  = ctrlb_r;
  assign LANE_CHECKSUM_0   = chk0_r;
  assign LANE_CHECKSUM_1   = chk1_r;
  assign ILAS_CFG_OCTET_0  = oct0_r;
  assign ILAS_CFG_OCTET_1  = oct1_r;

endmodule

// [verilog/jtl_link_params_params.svh]
// Purpose: Offsets, field positions, reset values of the link parameter bank
// Assumes: Register index times four is the AXI byte address
// Notes:   Definitions only
// What this block does
// RQ1: Eight-bit read-write device identity at 0x0580, reset zero, used by link.
// RQ2: Four-bit read-write bank identity at 0x0581, reset zero; top nibble reads zero.
// RQ3: Five-bit read-write first lane identity at 0x0583, reset zero; top bits zero.
// RQ4: Five-bit read-write second lane identity at 0x0585, reset two; top bits zero.
// RQ5: Bit 7 of 0x058B switches data whitening on; resets to one.
// RQ6: Read-only lane count at 0x058B [4:0] is lanes minus one; reset one.
// RQ7: Read-only octets per frame at 0x058C is value plus one; reset one.
// RQ8: Read-write frames per multiframe at 0x058D [4:0], value plus one, reset 0x1F.
// RQ9: Software programs only frame counts where octets times frames divide by four.
// RQ10: Read-only converter count at 0x058E codes one, two, four as 0,1,3; reset one.
// RQ11: Read-write control bits per sample select at 0x058F [7:6], reset zero.
// RQ12: Each lane checksum is the sum of its link parameters modulo 256.
// RQ13: Current parameters go out in each lane's alignment configuration octets.
`ifndef JTL_LINK_PARAMS_PARAMS_SVH
`define JTL_LINK_PARAMS_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define JTL_IDX_W        12
`define JTL_IDX_DEV      12'h580
`define JTL_IDX_BANK     12'h581
`define JTL_IDX_LANE0    12'h583
`define JTL_IDX_LANE1    12'h585
`define JTL_IDX_WHITEN   12'h58b
`define JTL_IDX_OCTETS   12'h58c
`define JTL_IDX_MFRAME   12'h58d
`define JTL_IDX_CONV     12'h58e
`define JTL_IDX_CTRLB    12'h58f

// ****************************************
// Field positions
// ****************************************
`define JTL_WHITEN_BIT   7
`define JTL_CTRLB_MSB    7
`define JTL_CTRLB_LSB    6

// ****************************************
// Reset values
// ****************************************
`define JTL_RST_DEV      8'h00
`define JTL_RST_BANK     4'h0
`define JTL_RST_LANE0    5'h00
`define JTL_RST_LANE1    5'h02
`define JTL_RST_WHITEN   1'b1
`define JTL_RST_LANES    5'h01
`define JTL_RST_OCTETS   8'h01
`define JTL_RST_MFRAME   5'h1f
`define JTL_RST_CONV     8'h01
`define JTL_RST_CTRLB    2'h0

// ****************************************
// Bus answers and alignment checksum octet index
// ****************************************
`define JTL_RESP_OKAY    2'b00
`define JTL_RESP_SLVERR  2'b10
`define JTL_ILAS_CHK_IDX 4'hd

`endif

// [verilog/jtl_pkg.sv]
// Purpose: Types shared by the link parameter bank
// Assumes: Nothing
// Notes:   Constants live in the params header
package jtl_pkg;

  // Control bits carried per sample
  typedef enum logic [1:0] {
    JTL_CS_NONE  = 2'b00,
    JTL_CS_BIT2  = 2'b01,
    JTL_CS_BIT21 = 2'b10,
    JTL_CS_ALL   = 2'b11
  } jtl_cs_t;

  typedef logic [7:0] jtl_octet_t;

endpackage
